// ---- hdl/vrmsc_pkg.sv ----
//==============================================================
// constants and types
//==============================================================
package vrmsc_pkg;
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int BOOT_HOLD_NS  = 50000;
	localparam int BOOT_HOLD_CYC =
		(BOOT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_W        = 20;
	// widths
	localparam int CODE_W        = 7;
	localparam int STEP_W        = 16;
	localparam int DIV_W         = STEP_W + 3;
	localparam int NSTAT         = 4;
	localparam int ADDR_W        = 8;
	// register byte offsets
	localparam logic [ADDR_W-1:0] ADDR_CTRL  = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_BOOT  = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_STAT  = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_MASK  = 8'h0c;
	localparam logic [ADDR_W-1:0] ADDR_STATE = 8'h10;
	// reset values
	localparam logic [STEP_W-1:0] STEP_RST   = 16'h0064;
	localparam logic [CODE_W-1:0] BOOT_RST   = 7'h30;
	localparam logic [CODE_W-1:0] OFF_CODE   = 7'h7f;
	// slew shifts: period = base << shift
	localparam logic [1:0] SH_FULL    = 2'h0;
	localparam logic [1:0] SH_QUARTER = 2'h2;
	localparam logic [1:0] SH_EIGHTH  = 2'h3;
	// status bits
	localparam int ST_BOOT = 0;
	localparam int ST_OFF  = 1;
	localparam int ST_SLOW = 2;
	localparam int ST_OVR  = 3;
	// state register fields
	localparam int STF_SKIP = 3;
	localparam int STF_TWO  = 4;
	localparam int STF_CODE = 8;
	// synchronised pin vector positions
	localparam int P_CODE = 0;
	localparam int P_POWER_DOWN_CTL_N = 7;
	localparam int P_OVR  = 8;
	localparam int P_DSR  = 9;
	localparam int P_DST  = 10;
	localparam int P_PSI  = 11;
	localparam int P_P2S  = 12;
	localparam int P_ZC1  = 13;
	localparam int P_ZC2  = 14;
	localparam int SYNC_W = 15;
	typedef enum logic [2:0] {
		S_OFF   = 3'h0,
		S_START = 3'h1,
		S_BOOT  = 3'h3,
		S_TOVID = 3'h2,
		S_RUN   = 3'h6,
		S_STOP  = 3'h7
	} vrmsc_state_t;
endpackage

// ---- hdl/vrmsc_slew_if.sv ----
`timescale 1ns/100ps
`default_nettype none
//==============================================================
// slew stepper link
//==============================================================
interface vrmsc_slew_if;
	logic       tick;
	logic [6:0] target;
	logic [6:0] current;
	logic       at_target;
	modport ctl  (output tick, output target,
	              input current, input at_target);
	modport ramp (input tick, input target,
	              output current, output at_target);
endinterface
`default_nettype wire

// ---- hdl/vrmsc_slew.sv ----
`timescale 1ns/100ps
`default_nettype none
//==============================================================
// one code step per tick toward the target
//==============================================================
module vrmsc_slew (
	// clock and reset
	input wire logic    pclk,
	input wire logic    presetn,
	// stepper link
	vrmsc_slew_if.ramp  sl
);
	import vrmsc_pkg::*;
	typedef struct packed {
		logic [CODE_W-1:0] cur;
	} vrmsc_slew_st_t;
	vrmsc_slew_st_t st_reg;
	vrmsc_slew_st_t st_next;

	always_comb begin
		st_next = st_reg;
		if (sl.tick) begin
			if (st_reg.cur < sl.target) begin
				st_next.cur = st_reg.cur + 7'h01;
			end else if (st_reg.cur > sl.target) begin
				st_next.cur = st_reg.cur - 7'h01;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg.cur <= OFF_CODE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign sl.current   = st_reg.cur;
	assign sl.at_target = (st_reg.cur == sl.target);

	//==============================================================
	// checks
	//==============================================================
	a_step_up:
	assert property (@(posedge pclk) disable iff (!presetn)
		(sl.tick && sl.current < sl.target) |=>
		sl.current == $past(sl.current) + 7'h01)
	else $error("code did not step up");
	a_step_down:
	assert property (@(posedge pclk) disable iff (!presetn)
		(sl.tick && sl.current > sl.target) |=>
		sl.current == $past(sl.current) - 7'h01)
	else $error("code did not step down");
	a_hold_still:
	assert property (@(posedge pclk) disable iff (!presetn)
		!sl.tick |=> $stable(sl.current))
	else $error("code moved without a tick");
endmodule
`default_nettype wire

// ---- hdl/vrmsc_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module vrmsc_top #(
	parameter int BOOT_HOLD = vrmsc_pkg::BOOT_HOLD_CYC
) (
	// clock and reset
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	// apb slave
	input  wire logic [vrmsc_pkg::ADDR_W-1:0]  paddr,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// cpu and system pins
	input  wire logic [vrmsc_pkg::CODE_W-1:0]  voltage_code_in,
	input  wire logic                          power_down_ctl_n,
	input  wire logic                          power_down_override,
	input  wire logic                          deep_sleep_request,
	input  wire logic                          deep_stop_in,
	input  wire logic                          power_state_hint,
	// phase pins and pwm loop
	input  wire logic                          phase2_sense_in,
	input  wire logic                          zero_cross1_in,
	input  wire logic                          zero_cross2_in,
	input  wire logic                          low_req1,
	input  wire logic                          low_req2,
	// control outputs
	output logic [vrmsc_pkg::CODE_W-1:0]       target_code,
	output logic                               regulator_on,
	output logic                               skip_mode,
	output logic                               two_phase,
	output logic                               pgood_upper_en,
	output logic                               overvoltage_protect_en,
	output logic                               undervoltage_protect_en,
	output logic                               fault_latch_clear,
	output logic                               phase_overlap_en,
	output logic                               boost_charge_switch_en,
	output logic                               phase1_low_drive,
	output logic                               phase2_low_drive,
	// interrupt
	output logic                               irq
);
	import vrmsc_pkg::*;

	//==============================================================
	// state
	//==============================================================
	typedef struct packed {
		logic [SYNC_W-1:0] s1;
		logic [SYNC_W-1:0] s2;
		vrmsc_state_t      state;
		logic [DIV_W-1:0]  cnt;
		logic              tick;
		logic [HOLD_W-1:0] hold;
		logic [STEP_W-1:0] step_base;
		logic [CODE_W-1:0] boot_code;
		logic [NSTAT-1:0]  stat;
		logic [NSTAT-1:0]  mask;
		logic [31:0]       rdata;
		logic              perr;
		logic              skip;
		logic              two;
		logic              pg_up;
		logic              overvoltage_protect;
		logic              undervoltage_protect;
		logic              fclr;
		logic              ovl;
		logic              bst;
		logic              dl1;
		logic              dl2;
		logic              zcl1;
		logic              zcl2;
		logic              slow_d;
		logic              ovr_d;
	} vrmsc_st_t;
	vrmsc_st_t st_reg;
	vrmsc_st_t st_next;

	vrmsc_slew_if sl ();

	vrmsc_slew u_slew (
		.pclk    (pclk),
		.presetn (presetn),
		.sl      (sl)
	);

	//==============================================================
	// helpers
	//==============================================================
	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		if (a == ADDR_CTRL) begin
			addr_ok = 1'b1;
		end else if (a == ADDR_BOOT) begin
			addr_ok = 1'b1;
		end else if (a == ADDR_STAT) begin
			addr_ok = 1'b1;
		end else if (a == ADDR_MASK) begin
			addr_ok = 1'b1;
		end else if (a == ADDR_STATE) begin
			addr_ok = 1'b1;
		end else begin
			addr_ok = 1'b0;
		end
	endfunction

	function automatic logic [1:0] rate_shift(input vrmsc_state_t s,
	                                          input logic slow);
		case (s)
			S_START, S_STOP: rate_shift = SH_EIGHTH;
			S_TOVID, S_RUN: rate_shift = slow ? SH_QUARTER : SH_FULL;
			default: rate_shift = SH_FULL;
		endcase
	endfunction

	// synchronised pins and derived internal signals
	logic [CODE_W-1:0] code_s;
	logic              power_down_ctl_n_n_s;
	logic              ovr_s;
	logic              dsr_s;
	logic              dst_s;
	logic              psi_s;
	logic              p2s_s;
	logic              zc1_s;
	logic              zc2_s;
	logic              slow;
	logic [1:0]        shift;
	logic [DIV_W-1:0]  period;
	logic              forced;
	logic              wr;
	logic [NSTAT-1:0]  set;
	logic [NSTAT-1:0]  clr;

	assign code_s   = st_reg.s2[P_CODE +: CODE_W];
	assign power_down_ctl_n_n_s = st_reg.s2[P_POWER_DOWN_CTL_N];
	assign ovr_s    = st_reg.s2[P_OVR];
	assign dsr_s    = st_reg.s2[P_DSR];
	assign dst_s    = st_reg.s2[P_DST];
	assign psi_s    = st_reg.s2[P_PSI];
	assign p2s_s    = st_reg.s2[P_P2S];
	assign zc1_s    = st_reg.s2[P_ZC1];
	assign zc2_s    = st_reg.s2[P_ZC2];
	assign slow     = dsr_s & dst_s;
	assign shift    = rate_shift(st_reg.state, slow);
	assign period   = {3'h0, st_reg.step_base} << shift;
	assign forced   = (st_reg.state != S_RUN);
	assign wr       = psel & penable & pwrite;

	//==============================================================
	// next state
	//==============================================================
	always_comb begin
		st_next = st_reg;
		set = '0;
		clr = '0;
		st_next.s1 = {zero_cross2_in, zero_cross1_in, phase2_sense_in,
		              power_state_hint, deep_stop_in, deep_sleep_request,
		              power_down_override, power_down_ctl_n,
		              voltage_code_in};
		st_next.s2 = st_reg.s1;
		st_next.tick = 1'b0;
		// sequencer
		case (st_reg.state)
			S_OFF: begin
				if (power_down_ctl_n_n_s) begin
					st_next.state = S_START;
				end
			end
			S_START: begin
				if (sl.at_target) begin
					st_next.state = S_BOOT;
					st_next.hold = '0;
					set[ST_BOOT] = 1'b1;
				end
			end
			S_BOOT: begin
				if (st_reg.hold >= HOLD_W'(BOOT_HOLD - 1)) begin
					st_next.state = S_TOVID;
				end else begin
					st_next.hold = st_reg.hold + 20'h00001;
				end
			end
			S_TOVID: begin
				if (sl.at_target) begin
					st_next.state = S_RUN;
				end
			end
			S_STOP: begin
				if (sl.at_target) begin
					st_next.state = S_OFF;
					set[ST_OFF] = 1'b1;
				end
			end
			S_RUN: begin
				st_next.state = S_RUN;
			end
			default: begin
				st_next.state = S_OFF;
			end
		endcase
		if (!power_down_ctl_n_n_s && st_reg.state != S_OFF &&
		    st_reg.state != S_STOP) begin
			st_next.state = S_STOP;
		end
		// slew rate divider
		if (st_reg.state == S_OFF || sl.at_target) begin
			st_next.cnt = '0;
		end else if (st_reg.cnt + 19'h00001 >= period) begin
			st_next.cnt = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.cnt = st_reg.cnt + 19'h00001;
		end
		// operating mode
		st_next.skip = !forced && dsr_s;
		st_next.two = !p2s_s && (forced || (!dsr_s && psi_s));
		st_next.pg_up = !st_next.skip;
		// override condition
		st_next.overvoltage_protect = !ovr_s;
		st_next.undervoltage_protect = !ovr_s;
		st_next.fclr = ovr_s;
		st_next.ovl = !ovr_s;
		st_next.bst = !ovr_s;
		// low-side drives
		st_next.zcl1 = low_req1 && (st_reg.zcl1 || zc1_s);
		st_next.zcl2 = low_req2 && (st_reg.zcl2 || zc2_s);
		st_next.dl1 = low_req1 &&
		              !(st_reg.skip && (st_reg.zcl1 || zc1_s));
		st_next.dl2 = low_req2 && st_reg.two &&
		              !(st_reg.skip && (st_reg.zcl2 || zc2_s));
		// events
		st_next.slow_d = slow;
		st_next.ovr_d = ovr_s;
		set[ST_SLOW] = slow && !st_reg.slow_d;
		set[ST_OVR] = ovr_s && !st_reg.ovr_d;
		// apb write
		if (wr) begin
			if (paddr == ADDR_CTRL) begin
				st_next.step_base = pwdata[STEP_W-1:0];
			end else if (paddr == ADDR_BOOT) begin
				st_next.boot_code = pwdata[CODE_W-1:0];
			end else if (paddr == ADDR_STAT) begin
				clr = pwdata[NSTAT-1:0];
			end else if (paddr == ADDR_MASK) begin
				st_next.mask = pwdata[NSTAT-1:0];
			end
		end
		st_next.stat = (st_reg.stat & ~clr) | set;
		// apb read data prepared in the setup cycle
		if (psel && !penable) begin
			st_next.perr = !addr_ok(paddr) ||
			               (pwrite && paddr == ADDR_STATE);
			st_next.rdata = '0;
			if (!pwrite) begin
				if (paddr == ADDR_CTRL) begin
					st_next.rdata[STEP_W-1:0] = st_reg.step_base;
				end else if (paddr == ADDR_BOOT) begin
					st_next.rdata[CODE_W-1:0] = st_reg.boot_code;
				end else if (paddr == ADDR_STAT) begin
					st_next.rdata[NSTAT-1:0] = st_reg.stat;
				end else if (paddr == ADDR_MASK) begin
					st_next.rdata[NSTAT-1:0] = st_reg.mask;
				end else if (paddr == ADDR_STATE) begin
					st_next.rdata[2:0] = st_reg.state;
					st_next.rdata[STF_SKIP] = st_reg.skip;
					st_next.rdata[STF_TWO] = st_reg.two;
					st_next.rdata[STF_CODE +: CODE_W] = sl.current;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.step_base <= STEP_RST;
			st_reg.boot_code <= BOOT_RST;
			st_reg.pg_up <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	//==============================================================
	// outputs
	//==============================================================
	always_comb begin
		case (st_reg.state)
			S_OFF, S_STOP: sl.target = OFF_CODE;
			S_START, S_BOOT: sl.target = st_reg.boot_code;
			default: sl.target = code_s;
		endcase
	end
	assign sl.tick                 = st_reg.tick;
	assign target_code             = sl.current;
	assign regulator_on            = (st_reg.state != S_OFF);
	assign skip_mode               = st_reg.skip;
	assign two_phase               = st_reg.two;
	assign pgood_upper_en          = st_reg.pg_up;
	assign overvoltage_protect_en  = st_reg.overvoltage_protect;
	assign undervoltage_protect_en = st_reg.undervoltage_protect;
	assign fault_latch_clear       = st_reg.fclr;
	assign phase_overlap_en        = st_reg.ovl;
	assign boost_charge_switch_en  = st_reg.bst;
	assign phase1_low_drive        = st_reg.dl1;
	assign phase2_low_drive        = st_reg.dl2;
	assign prdata                  = st_reg.rdata;
	assign pslverr                 = st_reg.perr;
	assign pready                  = 1'b1;
	assign irq                     = |(st_reg.stat & st_reg.mask);

	//==============================================================
	// checks
	//==============================================================
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_power_down_ctl_n_stop:
	assert property (!power_down_ctl_n_n_s && st_reg.state inside {S_START, S_BOOT,
		S_TOVID, S_RUN} |=> st_reg.state == S_STOP)
	else $error("shutdown did not start");
	a_start_rate:
	assert property (st_reg.state == S_START |->
		period == {st_reg.step_base, 3'h0})
	else $error("startup rate not one eighth");
	a_stop_rate:
	assert property (st_reg.state == S_STOP |->
		period == {st_reg.step_base, 3'h0})
	else $error("shutdown rate not one eighth");
	a_override_off:
	assert property (ovr_s |=> !overvoltage_protect_en &&
		!undervoltage_protect_en && fault_latch_clear &&
		!phase_overlap_en && !boost_charge_switch_en)
	else $error("override did not disable protection");
	a_pgood_blank:
	assert property (pgood_upper_en == !skip_mode)
	else $error("power good upper check not blanked");
	a_forced_pwm:
	assert property (forced |=> !skip_mode && two_phase == !$past(p2s_s))
	else $error("pwm not forced");
	a_quarter_rate:
	assert property (st_reg.state == S_RUN && slow |->
		period == {1'b0, st_reg.step_base, 2'h0})
	else $error("deep stop rate not one quarter");
	a_skip_dsr:
	assert property (st_reg.state == S_RUN && dsr_s && !dst_s |=>
		skip_mode && !two_phase)
	else $error("no single phase skip");
	a_phase_count:
	assert property (!forced && !dsr_s |=> !skip_mode &&
		two_phase == ($past(psi_s) && !$past(p2s_s)))
	else $error("phase count wrong");
	a_full_rate:
	assert property (st_reg.state == S_RUN && !slow |->
		period == {3'h0, st_reg.step_base})
	else $error("normal rate not full");
	a_dl2_single:
	assert property (!two_phase |=> !phase2_low_drive)
	else $error("phase 2 low drive in single phase");
	a_dl1_zero:
	assert property (skip_mode && zc1_s |=> !phase1_low_drive)
	else $error("low drive on after zero crossing");
endmodule
`default_nettype wire

// ---- dv/vrmsc_sys_model.sv ----
`timescale 1ns/100ps
`default_nettype none
//==============================================================
// cpu and system pin driver
//==============================================================
module vrmsc_sys_model (
	// clock
	input  wire logic                     pclk,
	// pins toward the regulator
	output logic [vrmsc_pkg::CODE_W-1:0]  voltage_code_in,
	output logic                          power_down_ctl_n,
	output logic                          power_down_override,
	output logic                          deep_sleep_request,
	output logic                          deep_stop_in,
	output logic                          power_state_hint,
	output logic                          phase2_sense_in
);
	import vrmsc_pkg::*;
	initial begin
		voltage_code_in = 7'h70;
		power_down_ctl_n = 1'b0;
		power_down_override = 1'b0;
		deep_sleep_request = 1'b0;
		deep_stop_in = 1'b1;
		power_state_hint = 1'b1;
		phase2_sense_in = 1'b0;
	end
	task automatic set_code(input logic [CODE_W-1:0] c);
		@(posedge pclk);
		voltage_code_in <= c;
	endtask
	task automatic set_power(input logic on);
		@(posedge pclk);
		power_down_ctl_n <= on;
	endtask
	task automatic set_ovr(input logic o);
		@(posedge pclk);
		power_down_override <= o;
	endtask
	// stop follows the complement of sleep except on deepest-sleep exit
	task automatic set_sleep(input logic dsr, input logic deep_exit);
		@(posedge pclk);
		deep_sleep_request <= dsr;
		deep_stop_in <= ~dsr | (dsr & deep_exit);
	endtask
	task automatic set_phases(input logic hint, input logic p2s);
		@(posedge pclk);
		power_state_hint <= hint;
		phase2_sense_in <= p2s;
	endtask
endmodule
`default_nettype wire

// ---- dv/vrmsc_top_bench.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) \
	begin n_fail++; \
	$display("unexpected %s expected %h seen %h", nm, ex, got); end end
//==============================================================
// bench top
//==============================================================
module vrmsc_top_bench;
	import vrmsc_pkg::*;
	localparam int BASE = 2;
	logic        pclk, presetn, psel, penable, pwrite, err;
	logic        low_req1, low_req2, zero_cross1_in, zero_cross2_in;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, regulator_on, skip_mode, two_phase;
	logic        pgood_upper_en, overvoltage_protect_en, irq;
	logic        undervoltage_protect_en, fault_latch_clear;
	logic        phase_overlap_en, boost_charge_switch_en;
	logic        phase1_low_drive, phase2_low_drive;
	logic [6:0]  target_code;
	wire logic [6:0] voltage_code_in;
	wire logic   power_down_ctl_n, power_down_override, deep_sleep_request;
	wire logic   deep_stop_in, power_state_hint, phase2_sense_in;
	int          n_fail, samples_checked, n;
	vrmsc_top #(.BOOT_HOLD(4)) dut (.pclk, .presetn, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.voltage_code_in, .power_down_ctl_n, .power_down_override,
		.deep_sleep_request, .deep_stop_in, .power_state_hint,
		.phase2_sense_in, .zero_cross1_in, .zero_cross2_in, .low_req1,
		.low_req2, .target_code, .regulator_on, .skip_mode, .two_phase,
		.pgood_upper_en, .overvoltage_protect_en, .undervoltage_protect_en,
		.fault_latch_clear, .phase_overlap_en, .boost_charge_switch_en,
		.phase1_low_drive, .phase2_low_drive, .irq);
	vrmsc_sys_model sys (.pclk, .voltage_code_in, .power_down_ctl_n,
		.power_down_override, .deep_sleep_request, .deep_stop_in,
		.power_state_hint, .phase2_sense_in);
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cut();
		n_fail++;
		$display("unexpected wait expected done seen timeout");
		print_verdict();
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge pclk);
		#1;
	endtask
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) cut();
	endtask
	// length of the first full gap between code steps
	task automatic step_gap();
		logic [6:0] c;
		c = target_code;
		repeat (2) begin
			n = 0;
			while (target_code === c && n < 400) begin
				settle(1);
				n++;
			end
			c = target_code;
		end
		if (n >= 400) cut();
	endtask
	task automatic wait_code(input logic [6:0] c);
		int k;
		for (k = 0; target_code !== c && k < 4000; k++) settle(1);
		if (k >= 4000) cut();
	endtask
	task automatic t_reset();
		`CHK("target_code", OFF_CODE, target_code)
		`CHK("regulator_on", 1'b0, regulator_on)
		`CHK("pready", 1'b1, pready)
		apb(ADDR_CTRL, 1'b0, 32'h0);
		`CHK("ctrl", {16'h0000, STEP_RST}, rd)
		apb(ADDR_BOOT, 1'b0, 32'h0);
		`CHK("boot", {25'h0000000, BOOT_RST}, rd)
		apb(8'h20, 1'b0, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		apb(ADDR_STATE, 1'b1, 32'h0);
		`CHK("state write err", 1'b1, err)
		apb(ADDR_CTRL, 1'b1, BASE);
		apb(ADDR_BOOT, 1'b1, 32'h00000078);
		apb(ADDR_MASK, 1'b1, 32'h00000008);
		$display("test reset done");
	endtask
	task automatic t_start();
		sys.set_sleep(1'b1, 1'b0);
		sys.set_power(1'b1);
		step_gap();
		`CHK("start gap", BASE * 8, n)
		`CHK("start skip", 1'b0, skip_mode)
		wait_code(7'h78);
		sys.set_sleep(1'b0, 1'b0);
		wait_code(7'h70);
		settle(4);
		apb(ADDR_STATE, 1'b0, 32'h0);
		`CHK("state", S_RUN, rd[2:0])
		`CHK("state code", 7'h70, rd[14:8])
		$display("test start done");
	endtask
	task automatic t_run();
		sys.set_code(7'h00);
		settle(4);
		step_gap();
		`CHK("full gap", BASE, n)
		sys.set_sleep(1'b1, 1'b1);
		settle(6);
		step_gap();
		`CHK("quarter gap", BASE * 4, n)
		`CHK("c4 skip", 1'b1, skip_mode)
		`CHK("c4 two", 1'b0, two_phase)
		sys.set_sleep(1'b1, 1'b0);
		settle(6);
		step_gap();
		`CHK("sleep gap", BASE, n)
		`CHK("sleep skip", 1'b1, skip_mode)
		`CHK("pgood upper", 1'b0, pgood_upper_en)
		wait_code(7'h00);
		$display("test run done");
	endtask
	task automatic t_modes();
		sys.set_sleep(1'b0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			sys.set_phases(i[0], i[1]);
			settle(5);
			`CHK("phases", ~i[1] & i[0], two_phase)
			`CHK("pwm", 1'b0, skip_mode)
		end
		$display("test modes done");
	endtask
	task automatic t_lowside();
		sys.set_phases(1'b1, 1'b0);
		low_req1 <= 1'b1;
		low_req2 <= 1'b1;
		zero_cross1_in <= 1'b1;
		zero_cross2_in <= 1'b1;
		settle(5);
		`CHK("dl1 pwm", 1'b1, phase1_low_drive)
		`CHK("dl2 pwm", 1'b1, phase2_low_drive)
		sys.set_sleep(1'b1, 1'b0);
		settle(6);
		`CHK("dl1 skip", 1'b0, phase1_low_drive)
		`CHK("dl2 one", 1'b0, phase2_low_drive)
		@(posedge pclk);
		zero_cross1_in <= 1'b0;
		zero_cross2_in <= 1'b0;
		low_req1 <= 1'b0;
		settle(4);
		@(posedge pclk);
		low_req1 <= 1'b1;
		settle(3);
		`CHK("dl1 rearm", 1'b1, phase1_low_drive)
		$display("test lowside done");
	endtask
	task automatic t_override();
		apb(ADDR_STAT, 1'b1, 32'h0000000f);
		settle(2);
		`CHK("irq idle", 1'b0, irq)
		`CHK("ovp on", 1'b1, overvoltage_protect_en)
		sys.set_ovr(1'b1);
		settle(5);
		`CHK("ovp", 1'b0, overvoltage_protect_en)
		`CHK("uvp", 1'b0, undervoltage_protect_en)
		`CHK("overlap", 1'b0, phase_overlap_en)
		`CHK("boost", 1'b0, boost_charge_switch_en)
		`CHK("fault clr", 1'b1, fault_latch_clear)
		`CHK("irq set", 1'b1, irq)
		sys.set_ovr(1'b0);
		settle(5);
		`CHK("uvp back", 1'b1, undervoltage_protect_en)
		apb(ADDR_STAT, 1'b1, 32'h00000008);
		settle(2);
		`CHK("irq clear", 1'b0, irq)
		$display("test override done");
	endtask
	task automatic t_shutdown();
		sys.set_power(1'b0);
		settle(6);
		`CHK("stop skip", 1'b0, skip_mode)
		step_gap();
		`CHK("stop gap", BASE * 8, n)
		wait_code(OFF_CODE);
		settle(4);
		`CHK("off", 1'b0, regulator_on)
		apb(ADDR_STAT, 1'b0, 32'h0);
		`CHK("off status", 1'b1, rd[ST_OFF])
		$display("test shutdown done");
	endtask
	initial begin
		n_fail = 0;
		samples_checked = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		low_req1 = 1'b0;
		low_req2 = 1'b0;
		zero_cross1_in = 1'b0;
		zero_cross2_in = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		settle(1);
		t_reset();
		t_start();
		t_run();
		t_modes();
		t_lowside();
		t_override();
		t_shutdown();
		print_verdict();
	end
endmodule
`default_nettype wire
